// ### src/amc_regs.svh
// Purpose: Constants for the accumulator motion command executor
// Assumes: Frames of nine bytes, 32-bit values sent most significant first
// Notes: Opcodes and status codes in hex form as used on the wire
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH
`define AMC_OP_MOVE_ACC 8'h2E
`define AMC_OP_ROT_LEFT_ACC 8'h32
`define AMC_OP_ROT_RIGHT_ACC 8'h33
`define AMC_OP_SET_IDX_VAR 8'h37
`define AMC_OP_MOTOR_STOP 8'h03
`define AMC_OP_TURN_RIGHT 8'h01
`define AMC_OP_TURN_LEFT 8'h02
`define AMC_TYPE_FIXED 8'h00
`define AMC_TYPE_OFFSET 8'h01
`define AMC_TYPE_SAVED 8'h02
`define AMC_ST_OK 8'h64
`define AMC_ST_BAD_CMD 8'h02
`define AMC_ST_BAD_TYPE 8'h03
`define AMC_ST_BAD_SUM 8'h01
`define AMC_HOST_ADDR 8'h02
`define AMC_MODULE_ADDR 8'h01
`define AMC_FRAME_LEN 4'h9
`define AMC_IDX_MAX 32'h0000_00FF
`define AMC_AP_TARGET_POS 8'h00
`define AMC_AP_TARGET_VEL 8'h02
`endif

// ### src/amc_pkg.sv
// Purpose: Types for the accumulator motion command executor
// Assumes: Wire constants come from the constants header; type encodings are set here
// Notes: Types only
package amc_pkg;
   typedef enum logic [1:0] {
      AMC_MODE_IDLE = 2'b00,
      AMC_MODE_POS = 2'b01,
      AMC_MODE_VEL = 2'b10
   } amc_mode_t;
   typedef enum logic [1:0] {
      AMC_ST_RX = 2'b00,
      AMC_ST_EXEC = 2'b01,
      AMC_ST_TX = 2'b10
   } amc_state_t;
endpackage

// ### src/amc_uvar_mem.sv
// Purpose: User variable store, 256 words of 32 bits
// Assumes: One write or one read per cycle
// Notes: Read data comes out of a register
`timescale 1ns/100ps
`default_nettype none
module amc_uvar_mem #(
   parameter int AW = 8,
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule // amc_uvar_mem
`default_nettype wire

// ### src/amc_saved_point_target_type_mem.sv
// Purpose: Stored coordinate table for saved-point moves
// Assumes: Written by an outside coordinate port, read on a move
// Notes: Synchronous read with registered output
`timescale 1ns/100ps
`default_nettype none
module amc_saved_point_target_type_mem #(
   parameter int AW = 8,
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // amc_saved_point_target_type_mem
`default_nettype wire

// ### src/amc_cmd_exec.sv
// Contract
// - Opcode 46 moves to accumulator target
// - Type 0 fixed, 1 offset, 2 saved
// - Reply at once, accept next command
// - Stop or turn commands abandon positioning
// - Target arithmetic wraps at 32 bits
// - Move selects position mode, sets parameter 0
// - Opcode 50 velocity mode, count down
// - Opcode 51 velocity mode, count up
// - Opcode 55 writes value to indexed variable
// - Index outside 0..255 writes nothing
// - Successful commands answer status 100
//
// Purpose: Byte-wise command frame executor for accumulator motion commands
// Assumes: Byte stream from a same-clock receiver; accumulator, index and
//          actual position come from the surrounding interpreter
// Notes: Outputs all registered; reply bytes streamed with a strobe
//        Frames for other addresses are dropped without any reply
`timescale 1ns/100ps
`default_nettype none
`include "amc_regs.svh"
module amc_cmd_exec (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic [31:0] ACCUM,
   input wire logic [31:0] INDEX_REG,
   input wire logic [31:0] ACTUAL_POS,
   input wire logic POS_REACHED,
   input wire logic SAVED_POINT_TARGET_TYPE_WE,
   input wire logic [7:0] SAVED_POINT_TARGET_TYPE_ADDR,
   input wire logic [31:0] SAVED_POINT_TARGET_TYPE_DATA,
   output logic TX_VALID,
   output logic [7:0] TX_BYTE,
   output amc_pkg::amc_mode_t MOTION_MODE,
   output logic [31:0] TARGET_POS,
   output logic [31:0] TARGET_VEL,
   output logic DIR_DOWN,
   output logic MOVE_START,
   output logic UVAR_WE,
   output logic [7:0] UVAR_ADDR,
   output logic [31:0] UVAR_DATA
);
   import amc_pkg::*;

   amc_state_t state_r;
   logic [3:0] cnt_r;
   logic [7:0] sum_r;
   logic [7:0] f_addr_r, f_op_r, f_type_r, f_bank_r;
   logic [31:0] f_val_r;
   logic [7:0] st_code_r;
   logic [1:0] exec_ph_r;
   logic [7:0] tx_buf_r [0:8];
   logic [31:0] saved_point_target_type_rdata;
   logic [31:0] uvar_rdata;
   logic idx_ok;
   logic [7:0] tx_sum;
   logic [31:0] move_tgt;
   logic [31:0] move_dist;

   // Commands that end a positioning move in progress
   function automatic logic is_abandon(input logic [7:0] op);
      is_abandon = (op == `AMC_OP_MOTOR_STOP) || (op == `AMC_OP_TURN_LEFT) ||
                   (op == `AMC_OP_TURN_RIGHT) ||
                   (op == `AMC_OP_ROT_LEFT_ACC) ||
                   (op == `AMC_OP_ROT_RIGHT_ACC);
   endfunction

   // Opcodes outside this set answer with the unknown-command status
   function automatic logic is_known(input logic [7:0] op);
      is_known = (op == `AMC_OP_MOVE_ACC) || (op == `AMC_OP_SET_IDX_VAR) ||
                 is_abandon(op);
   endfunction

   // Offset moves wrap at 32 bits; the carry out is dropped on purpose
   function automatic logic [31:0] move_target(input logic [7:0] typ,
      input logic [31:0] acc, input logic [31:0] act,
      input logic [31:0] saved_point_target_type);
      case (typ)
         `AMC_TYPE_OFFSET: move_target = act + acc;
         `AMC_TYPE_SAVED: move_target = saved_point_target_type;
         default: move_target = acc;
      endcase
   endfunction

   // Signed test of the index: negative values have bit 31 set
   assign idx_ok = ($signed(INDEX_REG) >= 0) &&
                   (INDEX_REG <= `AMC_IDX_MAX);

   // Target per move type; the value field of the frame plays no part
   assign move_tgt = move_target(f_type_r, ACCUM, ACTUAL_POS,
                                 saved_point_target_type_rdata);
   assign move_dist = move_tgt - ACTUAL_POS;

   // Frame receive; bytes outside RX state are dropped, one frame at a time
   // A lost byte misaligns framing; there is no idle timeout to resync
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cnt_r <= 4'h0;
         sum_r <= 8'h00;
         f_addr_r <= 8'h00;
         f_op_r <= 8'h00;
         f_type_r <= 8'h00;
         f_bank_r <= 8'h00;
         f_val_r <= 32'h0000_0000;
      end else if (state_r == AMC_ST_RX && RX_VALID) begin
         case (cnt_r)
            4'h0: f_addr_r <= RX_BYTE;
            4'h1: f_op_r <= RX_BYTE;
            4'h2: f_type_r <= RX_BYTE;
            4'h3: f_bank_r <= RX_BYTE;
            4'h4, 4'h5, 4'h6, 4'h7: f_val_r <= {f_val_r[23:0], RX_BYTE};
            default: ;
         endcase
         // The checksum byte is not added to the running sum
         if (cnt_r == `AMC_FRAME_LEN - 4'h1) begin
            cnt_r <= 4'h0;
            sum_r <= 8'h00;
         end else begin
            cnt_r <= cnt_r + 4'h1;
            sum_r <= sum_r + RX_BYTE;
         end
      end else if (state_r == AMC_ST_TX && cnt_r == `AMC_FRAME_LEN) begin
         cnt_r <= 4'h0;
      end else if (state_r == AMC_ST_TX) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // Sequencer: receive, execute over two cycles, stream reply
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_r <= AMC_ST_RX;
         exec_ph_r <= 2'b00;
         st_code_r <= `AMC_ST_OK;
      end else begin
         case (state_r)
            AMC_ST_RX: begin
               if (RX_VALID && cnt_r == `AMC_FRAME_LEN - 4'h1) begin
                  if (f_addr_r != `AMC_MODULE_ADDR) begin
                     state_r <= AMC_ST_RX;
                  end else begin
                     state_r <= AMC_ST_EXEC;
                     exec_ph_r <= 2'b00;
                     if (RX_BYTE != sum_r) begin
                        st_code_r <= `AMC_ST_BAD_SUM;
                     end else if (!is_known(f_op_r)) begin
                        st_code_r <= `AMC_ST_BAD_CMD;
                     end else if (f_op_r == `AMC_OP_MOVE_ACC &&
                                  f_type_r > `AMC_TYPE_SAVED) begin
                        st_code_r <= `AMC_ST_BAD_TYPE;
                     end else begin
                        st_code_r <= `AMC_ST_OK;
                     end
                  end
               end
            end
            AMC_ST_EXEC: begin
               // Phase 0 waits for the coordinate read to settle
               exec_ph_r <= exec_ph_r + 2'b01;
               if (exec_ph_r == 2'b01) begin
                  state_r <= AMC_ST_TX;
               end
            end
            AMC_ST_TX: begin
               if (cnt_r == `AMC_FRAME_LEN) begin
                  state_r <= AMC_ST_RX;
               end
            end
            default: state_r <= AMC_ST_RX;
         endcase
      end
   end

   // Motion controller setup on the final execute phase
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         MOTION_MODE <= AMC_MODE_IDLE;
         TARGET_POS <= 32'h0000_0000;
         TARGET_VEL <= 32'h0000_0000;
         DIR_DOWN <= 1'b0;
         MOVE_START <= 1'b0;
      end else begin
         MOVE_START <= 1'b0;
         if (state_r == AMC_ST_EXEC && exec_ph_r == 2'b01 &&
             st_code_r == `AMC_ST_OK) begin
            case (f_op_r)
               `AMC_OP_MOVE_ACC: begin
                  MOTION_MODE <= AMC_MODE_POS;
                  MOVE_START <= 1'b1;
                  TARGET_POS <= move_tgt;
                  // Sign of the wrapped distance picks the shorter way
                  DIR_DOWN <= move_dist[31];
               end
               // Velocity commands end positioning through the mode change
               `AMC_OP_ROT_LEFT_ACC: begin
                  MOTION_MODE <= AMC_MODE_VEL;
                  TARGET_VEL <= ACCUM;
                  DIR_DOWN <= 1'b1;
               end
               `AMC_OP_ROT_RIGHT_ACC: begin
                  MOTION_MODE <= AMC_MODE_VEL;
                  TARGET_VEL <= ACCUM;
                  DIR_DOWN <= 1'b0;
               end
               `AMC_OP_MOTOR_STOP, `AMC_OP_TURN_LEFT,
               `AMC_OP_TURN_RIGHT: begin
                  // Positioning dropped; the velocity path handles the rest
                  MOTION_MODE <= AMC_MODE_IDLE;
               end
               default: ;
            endcase
         // A command executing in the same cycle wins over arrival
         end else if (MOTION_MODE == AMC_MODE_POS && POS_REACHED &&
                      !MOVE_START) begin
            MOTION_MODE <= AMC_MODE_IDLE;
         end
      end
   end

   // Indexed user variable write
   // A bad index still gets an OK reply; only the write is skipped
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         UVAR_WE <= 1'b0;
         UVAR_ADDR <= 8'h00;
         UVAR_DATA <= 32'h0000_0000;
      end else begin
         UVAR_WE <= 1'b0;
         if (state_r == AMC_ST_EXEC && exec_ph_r == 2'b01 &&
             st_code_r == `AMC_ST_OK && f_op_r == `AMC_OP_SET_IDX_VAR &&
             idx_ok) begin
            UVAR_WE <= 1'b1;
            UVAR_ADDR <= INDEX_REG[7:0];
            UVAR_DATA <= f_val_r;
         end
      end
   end

   // Read port kept for a later readback path; nothing reads it yet
   amc_uvar_mem #(
      .AW(8),
      .DW(32)
   ) u_uvar (
      .clk(SYS_CLK),
      .we(UVAR_WE),
      .addr(UVAR_ADDR),
      .wdata(UVAR_DATA),
      .rdata(uvar_rdata)
   );

   amc_saved_point_target_type_mem #(
      .AW(8),
      .DW(32)
   ) u_saved_point_target_type (
      .clk(SYS_CLK),
      .we(SAVED_POINT_TARGET_TYPE_WE),
      .waddr(SAVED_POINT_TARGET_TYPE_ADDR),
      .wdata(SAVED_POINT_TARGET_TYPE_DATA),
      .raddr(f_bank_r),
      .rdata(saved_point_target_type_rdata)
   );

   // Reply frame; value field echoes the accumulator as a don't-care
   // Captured once so the reply stays fixed while operands move on
   assign tx_sum = `AMC_HOST_ADDR + `AMC_MODULE_ADDR + st_code_r + f_op_r +
                   ACCUM[31:24] + ACCUM[23:16] + ACCUM[15:8] + ACCUM[7:0];

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         for (int i = 0; i < 9; i++) begin
            tx_buf_r[i] <= 8'h00;
         end
      end else if (state_r == AMC_ST_EXEC && exec_ph_r == 2'b01) begin
         tx_buf_r[0] <= `AMC_HOST_ADDR;
         tx_buf_r[1] <= `AMC_MODULE_ADDR;
         tx_buf_r[2] <= st_code_r;
         tx_buf_r[3] <= f_op_r;
         tx_buf_r[4] <= ACCUM[31:24];
         tx_buf_r[5] <= ACCUM[23:16];
         tx_buf_r[6] <= ACCUM[15:8];
         tx_buf_r[7] <= ACCUM[7:0];
         tx_buf_r[8] <= tx_sum;
      end
   end

   // Bytes arriving while the reply streams are dropped, not queued
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         TX_VALID <= 1'b0;
         TX_BYTE <= 8'h00;
      end else if (state_r == AMC_ST_TX && cnt_r < `AMC_FRAME_LEN) begin
         TX_VALID <= 1'b1;
         TX_BYTE <= tx_buf_r[cnt_r];
      end else begin
         TX_VALID <= 1'b0;
         TX_BYTE <= 8'h00;
      end
   end
endmodule // amc_cmd_exec
`default_nettype wire

// ### test/amc_cmd_exec_properties.sv
// Purpose: Port-level properties of the command executor
// Assumes: Bench holds ACCUM and INDEX_REG steady across a command
// Notes: Bound onto the executor; a reply is nine strobed bytes
`timescale 1ns/100ps
`default_nettype none
module amc_cmd_exec_properties (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [31:0] ACCUM,
   input wire logic [31:0] INDEX_REG,
   input wire logic TX_VALID,
   input wire logic [7:0] TX_BYTE,
   input wire amc_pkg::amc_mode_t MOTION_MODE,
   input wire logic [31:0] TARGET_VEL,
   input wire logic MOVE_START,
   input wire logic UVAR_WE,
   input wire logic [7:0] UVAR_ADDR
);
   import amc_pkg::*;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   property p_move_pos;
      MOVE_START |-> MOTION_MODE == AMC_MODE_POS;
   endproperty
   a_move_pos: assert property (p_move_pos)
      else $error("move start outside position mode");
   property p_move_pulse;
      MOVE_START |=> !MOVE_START;
   endproperty
   a_move_pulse: assert property (p_move_pulse)
      else $error("move start longer than one cycle");
   // Reply must follow at once, not after arrival
   property p_move_reply;
      MOVE_START |-> ##[0:12] $rose(TX_VALID);
   endproperty
   a_move_reply: assert property (p_move_reply)
      else $error("no prompt reply to a move");
   // Length of the running strobe, counted instead of a long repeat
   logic [3:0] tx_run_r;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         tx_run_r <= 4'h0;
      end else if (TX_VALID) begin
         tx_run_r <= tx_run_r + 4'h1;
      end else begin
         tx_run_r <= 4'h0;
      end
   end
   property p_tx_len;
      $fell(TX_VALID) |-> tx_run_r == 4'h9;
   endproperty
   a_tx_len: assert property (p_tx_len)
      else $error("reply is not nine bytes");
   property p_tx_hdr;
      $rose(TX_VALID) |-> TX_BYTE == 8'h02 ##1 TX_BYTE == 8'h01;
   endproperty
   a_tx_hdr: assert property (p_tx_hdr)
      else $error("reply address bytes wrong");
   property p_vel_tgt;
      MOTION_MODE == AMC_MODE_VEL && $changed(TARGET_VEL)
         |-> TARGET_VEL == ACCUM;
   endproperty
   a_vel_tgt: assert property (p_vel_tgt)
      else $error("target velocity differs from accumulator");
   property p_uvar_range;
      UVAR_WE |-> INDEX_REG[31:8] == 24'h00_0000
         && UVAR_ADDR == INDEX_REG[7:0];
   endproperty
   a_uvar_range: assert property (p_uvar_range)
      else $error("user variable write with bad index");
   property p_uvar_pulse;
      UVAR_WE |=> !UVAR_WE;
   endproperty
   a_uvar_pulse: assert property (p_uvar_pulse)
      else $error("user variable write repeated");
endmodule // amc_cmd_exec_properties
bind amc_cmd_exec amc_cmd_exec_properties u_props (.SYS_CLK(SYS_CLK),
   .RST(RST), .ACCUM(ACCUM), .INDEX_REG(INDEX_REG), .TX_VALID(TX_VALID),
   .TX_BYTE(TX_BYTE), .MOTION_MODE(MOTION_MODE), .TARGET_VEL(TARGET_VEL),
   .MOVE_START(MOVE_START), .UVAR_WE(UVAR_WE), .UVAR_ADDR(UVAR_ADDR));
`default_nettype wire

// ### test/amc_host_model.sv
// Purpose: Host that sends command frames and gathers replies
// Assumes: Bytes launched on the falling clock edge
// Notes: Idle data line shows the inverse of the last byte
`timescale 1ns/100ps
`default_nettype none
module amc_host_model (
   input wire logic SYS_CLK,
   input wire logic TX_VALID,
   input wire logic [7:0] TX_BYTE,
   output logic RX_VALID,
   output logic [7:0] RX_BYTE
);
   logic [7:0] rep [0:8];
   int rep_cnt;
   initial begin
      RX_VALID = 1'b0;
      RX_BYTE = 8'h00;
      rep_cnt = 0;
   end
   always @(posedge SYS_CLK) begin
      if (TX_VALID === 1'b1 && rep_cnt < 9) begin
         rep[rep_cnt] <= TX_BYTE;
         rep_cnt <= rep_cnt + 1;
      end
   end
   task automatic send(input logic [7:0] op, input logic [7:0] typ,
      input logic [7:0] bank, input logic [31:0] val, input logic bad);
      logic [7:0] f [0:8];
      f = '{8'h01, op, typ, bank, val[31:24], val[23:16], val[15:8],
         val[7:0], 8'h00};
      for (int i = 0; i < 8; i++) f[8] += f[i];
      f[8] ^= {7'h00, bad};
      rep_cnt = 0;
      for (int i = 0; i < 9; i++) begin
         @(negedge SYS_CLK);
         RX_VALID = 1'b1;
         RX_BYTE = f[i];
      end
      @(negedge SYS_CLK);
      RX_VALID = 1'b0;
      RX_BYTE = ~f[8];
   endtask
endmodule // amc_host_model
`default_nettype wire

// ### test/amc_cmd_exec_test.sv
// Purpose: Self-checking bench for the command executor
// Assumes: Operands held steady from frame start to reply end
// Notes: Random operands from a fixed seed plus wrap and index corners
`timescale 1ns/100ps
`default_nettype none
`include "amc_regs.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
   error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module amc_cmd_exec_test;
   import amc_pkg::*;
   logic SYS_CLK, RST, RX_VALID, POS_REACHED, SAVED_POINT_TARGET_TYPE_WE, TX_VALID;
   logic DIR_DOWN, MOVE_START, UVAR_WE;
   logic [7:0] RX_BYTE, SAVED_POINT_TARGET_TYPE_ADDR, TX_BYTE, UVAR_ADDR, we_addr;
   logic [31:0] ACCUM, INDEX_REG, ACTUAL_POS, SAVED_POINT_TARGET_TYPE_DATA, TARGET_POS;
   logic [31:0] TARGET_VEL, UVAR_DATA, we_data, v;
   amc_mode_t MOTION_MODE;
   int error_cnt = 0, total_checks = 0, we_cnt = 0, n0, mv_cnt = 0;
   logic [7:0] stops [0:2] = '{`AMC_OP_MOTOR_STOP, `AMC_OP_TURN_LEFT,
      `AMC_OP_TURN_RIGHT};
   logic [31:0] idx [0:3] = '{32'h0000_0000, 32'h0000_00FF,
      32'hFFFF_FFFF, 32'h0000_0100};
   amc_host_model host (.SYS_CLK(SYS_CLK), .TX_VALID(TX_VALID),
      .TX_BYTE(TX_BYTE), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE));
   amc_cmd_exec dut (.SYS_CLK(SYS_CLK), .RST(RST), .RX_VALID(RX_VALID),
      .RX_BYTE(RX_BYTE), .ACCUM(ACCUM), .INDEX_REG(INDEX_REG),
      .ACTUAL_POS(ACTUAL_POS), .POS_REACHED(POS_REACHED),
      .SAVED_POINT_TARGET_TYPE_WE(SAVED_POINT_TARGET_TYPE_WE), .SAVED_POINT_TARGET_TYPE_ADDR(SAVED_POINT_TARGET_TYPE_ADDR),
      .SAVED_POINT_TARGET_TYPE_DATA(SAVED_POINT_TARGET_TYPE_DATA), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE),
      .MOTION_MODE(MOTION_MODE), .TARGET_POS(TARGET_POS),
      .TARGET_VEL(TARGET_VEL), .DIR_DOWN(DIR_DOWN),
      .MOVE_START(MOVE_START), .UVAR_WE(UVAR_WE), .UVAR_ADDR(UVAR_ADDR),
      .UVAR_DATA(UVAR_DATA));
   initial SYS_CLK = 1'b0;
   always #2 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) begin
      if (MOVE_START === 1'b1) mv_cnt++;
      if (UVAR_WE === 1'b1) begin
         we_cnt++;
         we_addr = UVAR_ADDR;
         we_data = UVAR_DATA;
      end
   end
   function automatic logic [7:0] exp_sum(logic [7:0] st, logic [7:0] op,
      logic [31:0] a);
      return 8'h03 + st + op + a[31:24] + a[23:16] + a[15:8] + a[7:0];
   endfunction
   // Shorter wrapped way decides the direction
   function automatic logic dir_exp(logic [31:0] t, logic [31:0] p);
      logic [31:0] d;
      d = t - p;
      return d[31];
   endfunction
   // Move target per type: fixed, offset from actual, saved point 5
   function automatic logic [31:0] exp_tgt(int t);
      return (t == 0) ? ACCUM : (t == 1) ? ACTUAL_POS + ACCUM : SAVED_POINT_TARGET_TYPE_DATA;
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic run(input logic [7:0] op, input logic [7:0] typ,
      input logic [31:0] val, input logic [7:0] st, input logic bad);
      int n;
      host.send(op, typ, 8'h05, val, bad);
      n = 0;
      while (host.rep_cnt < 9 && n < 60) begin
         @(posedge SYS_CLK);
         n++;
      end
      if (n == 60) begin
         error_cnt++;
         stop_test();
      end
      @(negedge SYS_CLK);
      `CHK(host.rep[2], st)
      `CHK(host.rep[3], op)
      `CHK(host.rep[8], exp_sum(st, op, ACCUM))
   endtask
   initial begin
      void'($urandom(32'h6E39));
      RST = 1'b1;
      {ACCUM, INDEX_REG, ACTUAL_POS, SAVED_POINT_TARGET_TYPE_DATA} = '0;
      {POS_REACHED, SAVED_POINT_TARGET_TYPE_WE, SAVED_POINT_TARGET_TYPE_ADDR} = '0;
      repeat (6) @(negedge SYS_CLK);
      RST = 1'b0;
      SAVED_POINT_TARGET_TYPE_WE = 1'b1;
      SAVED_POINT_TARGET_TYPE_ADDR = 8'h05;
      SAVED_POINT_TARGET_TYPE_DATA = $urandom;
      @(negedge SYS_CLK);
      SAVED_POINT_TARGET_TYPE_WE = 1'b0;
      for (int t = 0; t < 3; t++) begin
         for (int k = 0; k < 3; k++) begin
            ACCUM = (k == 0) ? 32'h8000_0010 : $urandom;
            ACTUAL_POS = (k == 0) ? 32'h0000_0000 : $urandom;
            n0 = mv_cnt;
            run(`AMC_OP_MOVE_ACC, t[7:0], $urandom, `AMC_ST_OK, 1'b0);
            `CHK(mv_cnt - n0, 1)
            `CHK(MOTION_MODE, AMC_MODE_POS)
            `CHK(TARGET_POS, exp_tgt(t))
            `CHK(DIR_DOWN, dir_exp(exp_tgt(t), ACTUAL_POS))
            run(stops[k], 8'h00, 32'h0000_0000, `AMC_ST_OK, 1'b0);
            `CHK(MOTION_MODE == AMC_MODE_POS, 1'b0)
         end
      end
      run(`AMC_OP_MOVE_ACC, 8'h01, 32'h0000_0000, `AMC_ST_OK, 1'b0);
      POS_REACHED = 1'b1;
      @(negedge SYS_CLK);
      POS_REACHED = 1'b0;
      @(negedge SYS_CLK);
      `CHK(MOTION_MODE, AMC_MODE_IDLE)
      for (int k = 0; k < 4; k++) begin
         ACCUM = $urandom;
         run(k[0] ? `AMC_OP_ROT_RIGHT_ACC : `AMC_OP_ROT_LEFT_ACC,
            8'($urandom), $urandom, `AMC_ST_OK, 1'b0);
         `CHK(MOTION_MODE, AMC_MODE_VEL)
         `CHK(TARGET_VEL, ACCUM)
         `CHK(DIR_DOWN, ~k[0])
      end
      for (int k = 0; k < 7; k++) begin
         INDEX_REG = (k < 4) ? idx[k] : {24'h00_0000, 8'($urandom)};
         v = $urandom;
         n0 = we_cnt;
         run(`AMC_OP_SET_IDX_VAR, 8'h00, v,
            (k == 6) ? `AMC_ST_BAD_SUM : `AMC_ST_OK, k == 6);
         `CHK(we_cnt - n0, int'(k != 6 && INDEX_REG < 256))
         if (k != 6 && INDEX_REG < 256) `CHK(we_addr, INDEX_REG[7:0])
         if (k != 6 && INDEX_REG < 256) `CHK(we_data, v)
      end
      n0 = mv_cnt;
      run(`AMC_OP_MOVE_ACC, 8'h03, 32'h0000_0000, `AMC_ST_BAD_TYPE, 1'b0);
      `CHK(mv_cnt - n0, 0)
      run(8'h30, 8'h00, 32'h0000_0000, `AMC_ST_BAD_CMD, 1'b0);
      stop_test();
   end
endmodule // amc_cmd_exec_test
`default_nettype wire
